// *** asf_cfg.svh ***
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH
// Register offsets
`define ASF_ADDR_STATUS 8'h00
`define ASF_ADDR_OUT_XM 8'h01
`define ASF_ADDR_OUT_XL 8'h02
`define ASF_ADDR_OUT_YM 8'h03
`define ASF_ADDR_OUT_YL 8'h04
`define ASF_ADDR_OUT_ZM 8'h05
`define ASF_ADDR_OUT_ZL 8'h06
`define ASF_ADDR_SETUP 8'h09
`define ASF_ADDR_RANGE 8'h0E
`define ASF_ADDR_TRIG 8'h0F
`define ASF_ADDR_CTRL1 8'h2A
`define ASF_ADDR_UOFS0 8'h2F
// Field positions
`define ASF_SETUP_MODE 7:6
`define ASF_SETUP_WMK 5:0
`define ASF_CTRL1_ACTIVE 0
`define ASF_CTRL1_FREAD 1
`define ASF_RANGE_SEL 1:0
`define ASF_TRIG_KEEP 5:0
`define ASF_STAT_OVF 7
`define ASF_STAT_WMK 6
`define ASF_TRIG_HIT 7
// Reset values
`define ASF_SETUP_RST 8'h00
`define ASF_CTRL1_RST 8'h00
`define ASF_RANGE_RST 8'h00
`define ASF_TRIG_RST 8'h00
`define ASF_UOFS_RST 8'h00
// Trim store and datapath constants
`define ASF_NVM_WORDS 3'h6
`define ASF_NVM_GAIN0 3'h3
`define ASF_GAIN_SHIFT 10
`define ASF_SAT_MAX 18'sh01FFF
`define ASF_SAT_MIN -18'sh02000
`endif

// *** asf_pkg.sv ***
package asf_pkg;
  typedef enum logic [1:0] {
    ASF_MODE_DIS = 2'h0,
    ASF_MODE_CIRC = 2'h1,
    ASF_MODE_FILL = 2'h2,
    ASF_MODE_TRIG = 2'h3
  } asf_mode_t;
  typedef enum logic [2:0] {
    ASF_ST_LOAD = 3'h1,
    ASF_ST_CAPT = 3'h2,
    ASF_ST_RUN = 3'h4
  } asf_state_t;
endpackage : asf_pkg

// *** asf_top.sv ***
`timescale 1ns/10ps
`include "asf_cfg.svh"

module asf_sample_queue #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH + 1),
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic overwrite,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic full;
  logic push;
  logic pop;
  logic rd_adv;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  assign full = (count == CW'(DEPTH));
  assign in_ready = !full || overwrite;
  assign out_valid = (count != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Overwrite when full drops the oldest entry
  assign rd_adv = pop || (push && full);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      count <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      if (rd_adv) begin
        rd_q <= nxt(rd_q);
      end
      count <= count + CW'(push) - CW'(rd_adv);
    end
  end
endmodule : asf_sample_queue

module asf_top #(
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  output logic nvm_rd,
  output logic [2:0] nvm_addr,
  input wire logic [7:0] nvm_rdata,
  output logic trim_done,
  input wire logic smp_valid,
  input wire logic signed [15:0] smp_x,
  input wire logic signed [15:0] smp_y,
  input wire logic signed [15:0] smp_z,
  input wire logic trig_event,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic queue_ovf,
  output logic queue_wmk
);
  localparam int CW = $clog2(DEPTH + 1);
  asf_pkg::asf_state_t st_q;
  logic [7:0] trim_q [6];
  logic [7:0] uofs_q [6];
  logic [7:0] setup_q;
  logic [7:0] ctrl1_q;
  logic [7:0] range_q;
  logic [7:0] trig_q;
  logic [41:0] latest_q;
  logic [41:0] fmt;
  logic [41:0] head;
  logic trig_hit_q;
  logic [5:0] post_q;
  logic [CW-1:0] q_count;
  logic q_valid;
  logic q_ready;
  asf_pkg::asf_mode_t mode;
  logic fread;
  logic accept;
  logic q_en;
  logic frozen;
  logic q_push;
  logic q_pop;
  logic q_flush;
  logic [1:0] rsh;
  logic [41:0] src;

  assign mode = asf_pkg::asf_mode_t'(setup_q[`ASF_SETUP_MODE]);
  assign fread = ctrl1_q[`ASF_CTRL1_FREAD];
  assign accept = smp_valid && trim_done && ctrl1_q[`ASF_CTRL1_ACTIVE];
  assign q_en = (mode != asf_pkg::ASF_MODE_DIS);
  assign frozen = (mode == asf_pkg::ASF_MODE_TRIG) && trig_hit_q
    && (post_q == trig_q[`ASF_TRIG_KEEP]);
  assign q_push = accept && q_en && !frozen && q_ready;
  assign q_pop = reg_rd && q_en && q_valid
    && (reg_addr == (fread ? `ASF_ADDR_OUT_ZM : `ASF_ADDR_OUT_ZL));
  // Any mode change restarts the queue so old and new data never mix
  assign q_flush = !q_en || (reg_wr && reg_addr == `ASF_ADDR_SETUP
    && reg_wdata[`ASF_SETUP_MODE] != setup_q[`ASF_SETUP_MODE]);
  // Shift from the 1/4096 g input scale to the selected range
  assign rsh = (range_q[`ASF_RANGE_SEL] == 2'h2) ? 2'h2
    : (range_q[`ASF_RANGE_SEL] == 2'h1) ? 2'h1 : 2'h0;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= asf_pkg::ASF_ST_LOAD;
      nvm_rd <= 1'b0;
      nvm_addr <= 3'h0;
      trim_done <= 1'b0;
    end else begin
      case (st_q)
        asf_pkg::ASF_ST_LOAD: begin
          nvm_rd <= 1'b1;
          st_q <= asf_pkg::ASF_ST_CAPT;
        end
        asf_pkg::ASF_ST_CAPT: begin
          nvm_rd <= 1'b0;
          if (nvm_addr == `ASF_NVM_WORDS - 3'h1) begin
            st_q <= asf_pkg::ASF_ST_RUN;
            trim_done <= 1'b1;
          end else begin
            nvm_addr <= nvm_addr + 3'h1;
            st_q <= asf_pkg::ASF_ST_LOAD;
          end
        end
        asf_pkg::ASF_ST_RUN: begin
          nvm_rd <= 1'b0;
        end
        default: begin
          st_q <= asf_pkg::ASF_ST_LOAD;
        end
      endcase
    end
  end

  // Trim words are captured at the end of the read strobe cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 6; i++) begin
        trim_q[i] <= 8'h00;
      end
    end else if (st_q == asf_pkg::ASF_ST_CAPT) begin
      trim_q[nvm_addr] <= nvm_rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      setup_q <= `ASF_SETUP_RST;
      ctrl1_q <= `ASF_CTRL1_RST;
      range_q <= `ASF_RANGE_RST;
      trig_q <= `ASF_TRIG_RST;
      for (int i = 0; i < 6; i++) begin
        uofs_q[i] <= `ASF_UOFS_RST;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `ASF_ADDR_SETUP: setup_q <= reg_wdata;
        `ASF_ADDR_CTRL1: ctrl1_q <= reg_wdata;
        `ASF_ADDR_RANGE: range_q <= reg_wdata;
        `ASF_ADDR_TRIG: trig_q <= reg_wdata;
        default: begin
          for (int i = 0; i < 6; i++) begin
            if (reg_addr == `ASF_ADDR_UOFS0 + 8'(i)) begin
              uofs_q[i] <= reg_wdata;
            end
          end
        end
      endcase
    end
  end

  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [15:0] raw;
    logic signed [17:0] t0;
    logic signed [25:0] prod;
    logic signed [17:0] t1;
    logic signed [17:0] t2;
    logic signed [17:0] uofs;
    logic signed [17:0] t3;
    assign raw = (a == 0) ? smp_x : (a == 1) ? smp_y : smp_z;
    assign t0 = 18'(raw) + 18'(signed'(trim_q[a]));
    assign prod = 26'(t0) * 26'(signed'(trim_q[a + `ASF_NVM_GAIN0]));
    assign t1 = t0 + 18'(prod >>> `ASF_GAIN_SHIFT);
    assign t2 = t1 >>> rsh;
    assign uofs = 18'(signed'({uofs_q[2*a], uofs_q[2*a+1][7:2]}));
    assign t3 = t2 + uofs;
    // Clip rather than wrap so a large offset never flips the sign
    assign fmt[14*a +: 14] = (t3 > `ASF_SAT_MAX) ? 14'h1FFF
      : (t3 < `ASF_SAT_MIN) ? 14'h2000 : t3[13:0];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      latest_q <= '0;
    end else if (accept) begin
      latest_q <= fmt;
    end
  end

  asf_sample_queue #(
    .WIDTH(42),
    .DEPTH(DEPTH)
  ) u_queue (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .flush(q_flush),
    .overwrite(mode != asf_pkg::ASF_MODE_FILL),
    .in_valid(accept && q_en && !frozen),
    .in_ready(q_ready),
    .in_data(fmt),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(head),
    .count(q_count)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trig_hit_q <= 1'b0;
      post_q <= 6'h00;
    end else if (mode != asf_pkg::ASF_MODE_TRIG || q_flush) begin
      trig_hit_q <= 1'b0;
      post_q <= 6'h00;
    end else begin
      if (trig_event) begin
        trig_hit_q <= 1'b1;
      end
      if (trig_hit_q && q_push) begin
        post_q <= post_q + 6'h01;
      end
    end
  end

  // Sticky overflow; a new overflow in the read cycle wins over the clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      queue_ovf <= 1'b0;
    end else if (!q_en) begin
      queue_ovf <= 1'b0;
    end else if (accept && q_count == CW'(DEPTH)) begin
      queue_ovf <= 1'b1;
    end else if (reg_rd && reg_addr == `ASF_ADDR_STATUS) begin
      queue_ovf <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      queue_wmk <= 1'b0;
    end else begin
      queue_wmk <= q_en && (setup_q[`ASF_SETUP_WMK] != 6'h00)
        && (q_count >= CW'(setup_q[`ASF_SETUP_WMK]));
    end
  end

  assign src = (q_en && q_valid) ? head : latest_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ASF_ADDR_STATUS: reg_rdata <= {queue_ovf, queue_wmk, 6'(q_count)};
        `ASF_ADDR_OUT_XM: reg_rdata <= src[13:6];
        `ASF_ADDR_OUT_XL: reg_rdata <= fread ? 8'h00 : {src[5:0], 2'h0};
        `ASF_ADDR_OUT_YM: reg_rdata <= src[27:20];
        `ASF_ADDR_OUT_YL: reg_rdata <= fread ? 8'h00 : {src[19:14], 2'h0};
        `ASF_ADDR_OUT_ZM: reg_rdata <= src[41:34];
        `ASF_ADDR_OUT_ZL: reg_rdata <= fread ? 8'h00 : {src[33:28], 2'h0};
        `ASF_ADDR_SETUP: reg_rdata <= setup_q;
        `ASF_ADDR_CTRL1: reg_rdata <= ctrl1_q;
        `ASF_ADDR_RANGE: reg_rdata <= range_q;
        `ASF_ADDR_TRIG: reg_rdata <= {trig_hit_q, 1'b0, trig_q[`ASF_TRIG_KEEP]};
        default: begin
          reg_rdata <= 8'h00;
          for (int i = 0; i < 6; i++) begin
            if (reg_addr == `ASF_ADDR_UOFS0 + 8'(i)) begin
              reg_rdata <= uofs_q[i];
            end
          end
        end
      endcase
    end
  end

  logic [3:0] nvm_cnt_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nvm_cnt_q <= 4'h0;
    end else if (nvm_rd) begin
      nvm_cnt_q <= nvm_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  trim_load_a: assert property ($rose(trim_done) |-> nvm_cnt_q == 4'h6)
    else $error("trim done before all trim words read");
  uofs_store_a: assert property (reg_wr && reg_addr == `ASF_ADDR_UOFS0
    |=> uofs_q[0] == $past(reg_wdata))
    else $error("user offset byte not stored");
  high_byte_a: assert property (reg_rd && reg_addr == `ASF_ADDR_OUT_XM && !q_en
    |=> reg_rdata == $past(latest_q[13:6]))
    else $error("high byte is not upper sample bits");
  fast_lsb_a: assert property (reg_rd && fread && reg_addr == `ASF_ADDR_OUT_YL
    |=> reg_rdata == 8'h00)
    else $error("low byte returned in fast read");
  fill_ovf_a: assert property (q_en && accept && q_count == CW'(DEPTH)
    |=> queue_ovf)
    else $error("overflow not raised");
  fill_hold_a: assert property (mode == asf_pkg::ASF_MODE_FILL && q_count == CW'(DEPTH)
    && !q_pop && !q_flush |=> q_count == CW'(DEPTH) && !$changed(head))
    else $error("full fill queue changed without a read");
  circ_keep_a: assert property (mode == asf_pkg::ASF_MODE_CIRC && q_count == CW'(DEPTH)
    && q_push && !q_pop && !q_flush |=> q_count == CW'(DEPTH))
    else $error("circular queue lost its depth");
  trig_stop_a: assert property (frozen && !q_pop && !q_flush |=> $stable(q_count))
    else $error("sample stored after post-trigger count");
  wmk_level_a: assert property (q_en && setup_q[`ASF_SETUP_WMK] != 6'h00
    && q_count >= CW'(setup_q[`ASF_SETUP_WMK]) |=> queue_wmk)
    else $error("watermark not flagged");
  dis_quiet_a: assert property (!q_en ##1 !q_en |-> q_count == '0
    && !queue_ovf && !queue_wmk)
    else $error("disabled queue not quiet");

  fill_ovf_c: cover property (mode == asf_pkg::ASF_MODE_FILL && $rose(queue_ovf));
  circ_wrap_c: cover property (mode == asf_pkg::ASF_MODE_CIRC && q_push
    && q_count == CW'(DEPTH));
  trig_freeze_c: cover property ($rose(frozen));
  wmk_hit_c: cover property ($rose(queue_wmk));
endmodule : asf_top

// *** asf_host_model.sv ***
`timescale 1ns/10ps
module asf_host_model #(
  parameter logic [7:0] OFS_X = 8'h08,
  parameter logic [7:0] GAIN_Z = 8'h10
) (
  input wire logic clk_sys,
  input wire logic nvm_rd,
  input wire logic [2:0] nvm_addr,
  output logic [7:0] nvm_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  logic [7:0] word;
  assign word = (nvm_addr == 3'h0) ? OFS_X : ((nvm_addr == 3'h5) ? GAIN_Z : 8'h00);
  initial begin
    nvm_rdata = 8'hA5;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Word is presented within the strobe cycle; off-cycle toggling exposes a wrong capture edge
  always @(negedge clk_sys) begin
    if (nvm_rd) begin
      nvm_rdata <= word;
    end else begin
      nvm_rdata <= ~nvm_rdata;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : asf_host_model

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  logic clk_sys, reset_n, nvm_rd, trim_done, smp_valid, trig_event;
  logic reg_wr, reg_rd, queue_ovf, queue_wmk;
  logic [2:0] nvm_addr;
  logic [7:0] nvm_rdata, reg_addr, reg_wdata, reg_rdata, d;
  logic signed [15:0] smp_x, smp_y, smp_z;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  asf_top #(.DEPTH(32)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata), .trim_done(trim_done),
    .smp_valid(smp_valid), .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z),
    .trig_event(trig_event), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .queue_ovf(queue_ovf),
    .queue_wmk(queue_wmk));
  asf_host_model u_host (.clk_sys(clk_sys), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
    .nvm_rdata(nvm_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  task automatic summarize;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  // Y and Z are fixed; Z carries the gain trim (1024 * 1040 / 1024)
  task automatic push(input int n, input int x0);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      smp_valid = 1'b1;
      smp_x = 16'(x0 + 4 * i);
      smp_y = -16'sd256;
      smp_z = 16'sd1024;
    end
    @(negedge clk_sys);
    smp_valid = 1'b0;
    smp_x = ~smp_x;
    repeat (2) @(negedge clk_sys);
  endtask : push
  task automatic rd_axis(input logic [7:0] a, input logic [13:0] s, input logic fast);
    u_host.rd(a, d);
    chk8(d, s[13:6]);
    if (!fast) begin
      u_host.rd(a + 8'h01, d);
      chk8(d, {s[5:0], 2'b00});
    end
  endtask : rd_axis
  task automatic rd_entry(input int xraw, input logic fast);
    rd_axis(8'h01, 14'(xraw + 8), fast);
    rd_axis(8'h03, -14'sd256, fast);
    rd_axis(8'h05, 14'd1040, fast);
  endtask : rd_entry
  task automatic rd_count(input logic [7:0] exp);
    u_host.rd(8'h00, d);
    chk8(d & 8'h3F, exp);
  endtask : rd_count

  task automatic t_reset;
    for (int i = 0; i < 40 && trim_done !== 1'b1; i++) @(negedge clk_sys);
    chk1(trim_done, 1'b1);
    u_host.rd(8'h09, d);
    chk8(d, 8'h00);
    u_host.rd(8'h7F, d);
    chk8(d, 8'h00);
  endtask : t_reset
  task automatic t_format;
    u_host.wr(8'h2A, 8'h01);
    push(1, 16'h0FF8);
    rd_entry(16'h0FF8, 1'b0);
    push(1, 16'h3000);
    rd_axis(8'h01, 14'h1FFF, 1'b0);
    u_host.wr(8'h2A, 8'h03);
    u_host.rd(8'h02, d);
    chk8(d, 8'h00);
    rd_axis(8'h01, 14'h1FFF, 1'b1);
    u_host.wr(8'h2A, 8'h01);
    u_host.wr(8'h0E, 8'h02);
    push(1, 16'h0FF8);
    rd_axis(8'h01, 14'h0400, 1'b0);
    u_host.wr(8'h0E, 8'h00);
    u_host.wr(8'h2F, 8'h01);
    u_host.wr(8'h30, 8'h10);
    push(1, 0);
    rd_axis(8'h01, 14'd76, 1'b0);
    u_host.wr(8'h2F, 8'h00);
    u_host.wr(8'h30, 8'h00);
  endtask : t_format
  task automatic t_fill;
    u_host.wr(8'h09, 8'h85);
    push(4, 0);
    chk1(queue_wmk, 1'b0);
    push(1, 16);
    chk1(queue_wmk, 1'b1);
    push(27, 20);
    chk1(queue_ovf, 1'b0);
    u_host.rd(8'h00, d);
    chk8(d, 8'h60);
    push(1, 500);
    chk1(queue_ovf, 1'b1);
    u_host.rd(8'h00, d);
    chk8(d, 8'hE0);
    chk1(queue_ovf, 1'b0);
    rd_entry(0, 1'b0);
    rd_count(8'h1F);
    push(1, 700);
    rd_count(8'h20);
  endtask : t_fill
  task automatic t_circ;
    u_host.wr(8'h09, 8'h40);
    push(34, 0);
    u_host.wr(8'h2A, 8'h03);
    rd_entry(8, 1'b1);
    rd_count(8'h1F);
    u_host.wr(8'h2A, 8'h01);
  endtask : t_circ
  task automatic t_trig;
    u_host.wr(8'h0F, 8'h02);
    u_host.wr(8'h09, 8'hC0);
    push(3, 0);
    trig_event = 1'b1;
    @(negedge clk_sys);
    trig_event = 1'b0;
    push(5, 100);
    rd_count(8'h05);
    u_host.rd(8'h0F, d);
    chk8(d & 8'h80, 8'h80);
  endtask : t_trig
  task automatic t_dis;
    u_host.wr(8'h09, 8'h05);
    push(8, 0);
    chk1(queue_ovf, 1'b0);
    chk1(queue_wmk, 1'b0);
    u_host.rd(8'h00, d);
    chk8(d, 8'h00);
  endtask : t_dis

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Whole run is a few hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    reset_n = 1'b0;
    smp_valid = 1'b0;
    smp_x = 16'sd0;
    smp_y = 16'sd0;
    smp_z = 16'sd0;
    trig_event = 1'b0;
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    t_reset();
    t_format();
    t_fill();
    t_circ();
    t_trig();
    t_dis();
    summarize();
  end
endmodule : tb
